// ### inc/tcm_regs.svh
/*
 * Register offsets, field positions, reset values and codes of the timer
 * capture channel. Assumes byte addresses on an 8-bit register port, one
 * 32-bit word per register.
 */
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH

`define TCM_ADDR_W 8
`define TCM_DATA_W 32
`define TCM_CNT_W 16
`define TCM_PRESC_W 16
`define TCM_EXP_W 4
`define TCM_MODE_W 9

`define TCM_OFS_MODE 8'h00
`define TCM_OFS_START 8'h04
`define TCM_OFS_STOP 8'h08
`define TCM_OFS_ENABLED 8'h0c
`define TCM_OFS_CAPTURE 8'h10
`define TCM_OFS_COUNT 8'h14
`define TCM_OFS_STATUS 8'h18
`define TCM_OFS_SWITCH 8'h1c
`define TCM_OFS_POWER 8'h20
`define TCM_OFS_PRESC 8'h24

`define TCM_TRIG_BIT 0
`define TCM_OVF_BIT 0
`define TCM_ENABLED_BIT 0
`define TCM_POWER_BIT 0
`define TCM_ROUTE_BIT 1
`define TCM_EXP0_LSB 0
`define TCM_EXP1_LSB 4

`define TCM_MODE_RESET 9'h000
`define TCM_PRESC_RESET 8'h00
`define TCM_STS_EDGE 3'h1
`define TCM_CIS_FALL 2'h0
`define TCM_CIS_RISE 2'h1
`define TCM_ROUTED_CHANNEL 1

`endif

// ### inc/tcm_pkg.sv
/*
 * Types shared by the timer capture channel modules.
 * Assumes tcm_regs.svh is on the include path.
 */
`include "tcm_regs.svh"

package tcm_pkg;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_count = 4'b0010,
        st_wait = 4'b0100,
        st_measure = 4'b1000
    } tcm_state_e;

    typedef enum logic {
        opm_interval = 1'b0,
        opm_width = 1'b1
    } tcm_opmode_e;

    // Layout of the channel mode register, bit 8 down to bit 0
    typedef struct packed {
        logic operating_clock_select;
        logic [1:0] edge_select;
        logic spare;
        tcm_opmode_e opmode;
        logic [2:0] trigger_source;
        logic start_interrupt_mode_bit;
    } tcm_mode_s;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } tcm_edge_s;

endpackage : tcm_pkg

// ### hdl/tcm_tick_gen.sv
/*
 * Operating clock tick generator: a free prescaler with two power-of-two
 * taps, one selected per channel. Assumes a single clock domain.
 */
`timescale 1ns/100ps
`include "tcm_regs.svh"

module tcm_tick_gen #(
    parameter int PW = `TCM_PRESC_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic run,
    input wire logic [`TCM_EXP_W-1:0] exp0,
    input wire logic [`TCM_EXP_W-1:0] exp1,
    input wire logic sel,
    output logic tick
);

    logic [PW-1:0] presc_reg;
    logic tick_reg;

    function automatic logic tap_hit(input logic [PW-1:0] cnt, input logic [`TCM_EXP_W-1:0] e);
        logic [PW-1:0] mask;
        mask = PW'((32'h1 << e) - 32'h1);
        return &(cnt | ~mask);
    endfunction : tap_hit

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            presc_reg <= '0;
        end else if (!run) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + PW'(1);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= run && (sel ? tap_hit(presc_reg, exp1) : tap_hit(presc_reg, exp0));
        end
    end

    assign tick = tick_reg;

endmodule : tcm_tick_gen

// ### hdl/tcm_input_sync.sv
/*
 * Timer input conditioning: synchronises both candidate pins, routes one,
 * samples it on the operating clock tick and reports edges.
 * Assumes pins are asynchronous to clock.
 */
`timescale 1ns/100ps
`include "tcm_regs.svh"

module tcm_input_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic run,
    input wire logic tick,
    input wire logic route,
    input wire logic timer_input,
    input wire logic serial_receive_input,
    output tcm_pkg::tcm_edge_s edge_evt
);

    logic [1:0] pin_raw;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic smp_reg;
    logic prev_reg;
    logic primed_reg;
    logic strobe_reg;
    logic chosen;

    assign pin_raw = {serial_receive_input, timer_input};

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= pin_raw[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    // Receive line replaces the timer pin when routed
    assign chosen = route ? sync2_reg[1] : sync2_reg[0];

    // Sampling only on the tick costs up to one operating clock of error
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            smp_reg <= 1'b0;
            prev_reg <= 1'b0;
            primed_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else if (!run) begin
            smp_reg <= 1'b0;
            prev_reg <= 1'b0;
            primed_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= tick;
            if (tick) begin
                smp_reg <= chosen;
                // First sample primes both stages, so an idle-high line gives no false edge
                prev_reg <= primed_reg ? smp_reg : chosen;
                primed_reg <= 1'b1;
            end
        end
    end

    assign edge_evt.level = smp_reg;
    assign edge_evt.rise = strobe_reg & smp_reg & ~prev_reg;
    assign edge_evt.fall = strobe_reg & ~smp_reg & prev_reg;

endmodule : tcm_input_sync

// ### hdl/tcm_channel.sv
/*
 * One timer channel in pulse-interval capture and level-width capture modes,
 * with its register port, start/stop triggers and overflow status.
 * Assumes a register master that issues one-cycle strobes on clock and takes
 * read data in the cycle after the read strobe.
 */
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "tcm_regs.svh"

// Function
// - Interval mode start makes the counter count up from zero each count clock.
// - Interval valid edge captures count, clears counter, raises interrupt together.
// - Each capture sets overflow flag if counter wrapped that period, else clears.
// - Two or more wraps still only set overflow; captured value invalid.
// - Start write while enabled in interval mode captures, synchronised to tick.
// - Start sets enabled, clears counter next count clock, interrupt if mode bit.
// - Stop clears enabled and halts counting; counter and overflow hold.
// - Start and stop trigger bits self-clear and read back as zero.
// - Input sampled on selected operating clock; one-cycle error possible.
// - Route bit 1 feeds serial receive input into channel 1's timer input.
// - Width mode start sets enabled and waits for the start edge.
// - Width mode start edge clears counter, then counts up each count clock.
// - Width mode capture edge stores count, raises interrupt, updates overflow.
// - After width capture counter stops at capture plus one, waits again.
// - Edge select 10 measures low width, 11 measures high width.
// - Power enable low stops the unit, blocks access, holds registers initialised.
module tcm_channel #(
    parameter int CNT_W = `TCM_CNT_W,
    parameter int CHANNEL = `TCM_ROUTED_CHANNEL
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`TCM_ADDR_W-1:0] addr,
    input wire logic [`TCM_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`TCM_DATA_W-1:0] rdata,
    input wire logic timer_input,
    input wire logic serial_receive_input,
    output logic channel_interrupt
);

    logic unit_power_enable_reg;
    tcm_pkg::tcm_mode_s channel_mode_reg;
    logic rx_to_timer_route_bit_reg;
    logic [2*`TCM_EXP_W-1:0] presc_reg;
    logic channel_enabled_flag_reg;
    tcm_pkg::tcm_state_e state_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] capture_reg;
    logic overflow_flag_reg;
    logic ovf_pend_reg;
    logic start_pend_reg;
    logic swcap_reg;
    logic irq_reg;
    logic [`TCM_DATA_W-1:0] rdata_reg;
    logic [`TCM_DATA_W-1:0] rdata_next;

    logic tick;
    tcm_pkg::tcm_edge_s edge_evt;
    logic route_eff;
    logic wr_on;
    logic start_wr;
    logic stop_wr;
    logic iv_edge;
    logic meas_high;
    logic start_edge;
    logic cap_edge;
    logic is_interval;
    logic cap_iv;
    logic cap_w;
    logic start_tick;
    logic wrap;

    function automatic logic reg_hit(input logic [`TCM_ADDR_W-1:0] a, input logic [`TCM_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : reg_hit

    tcm_tick_gen u_tick (
        .clock(clock),
        .nrst(nrst),
        .run(unit_power_enable_reg),
        .exp0(presc_reg[`TCM_EXP0_LSB +: `TCM_EXP_W]),
        .exp1(presc_reg[`TCM_EXP1_LSB +: `TCM_EXP_W]),
        .sel(channel_mode_reg.operating_clock_select),
        .tick(tick)
    );

    // Routing exists only on the channel wired to the serial receiver
    assign route_eff = rx_to_timer_route_bit_reg && (CHANNEL == `TCM_ROUTED_CHANNEL);

    tcm_input_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .run(unit_power_enable_reg),
        .tick(tick),
        .route(route_eff),
        .timer_input(timer_input),
        .serial_receive_input(serial_receive_input),
        .edge_evt(edge_evt)
    );

    // Everything but the power bit is unreachable while the unit is off
    assign wr_on = wr && unit_power_enable_reg;
    // Triggers have no storage, so they behave as self-clearing bits
    assign start_wr = wr_on && reg_hit(addr, `TCM_OFS_START) && wdata[`TCM_TRIG_BIT];
    assign stop_wr = wr_on && reg_hit(addr, `TCM_OFS_STOP) && wdata[`TCM_TRIG_BIT];
    assign is_interval = channel_mode_reg.opmode == tcm_pkg::opm_interval;

    // Interval-mode input edges trigger only with the edge trigger source
    always_comb begin
        case (channel_mode_reg.edge_select)
            `TCM_CIS_FALL: iv_edge = edge_evt.fall;
            `TCM_CIS_RISE: iv_edge = edge_evt.rise;
            default: iv_edge = edge_evt.rise | edge_evt.fall;
        endcase
        if (channel_mode_reg.trigger_source != `TCM_STS_EDGE) begin
            iv_edge = 1'b0;
        end
    end

    // Low bit of edge select picks high level (11) or low level (10)
    assign meas_high = channel_mode_reg.edge_select[0];
    assign start_edge = meas_high ? edge_evt.rise : edge_evt.fall;
    assign cap_edge = meas_high ? edge_evt.fall : edge_evt.rise;

    assign start_tick = state_reg == tcm_pkg::st_count && start_pend_reg && tick;
    assign cap_iv = state_reg == tcm_pkg::st_count && !start_pend_reg && !stop_wr
        && (iv_edge || (swcap_reg && tick));
    assign cap_w = state_reg == tcm_pkg::st_measure && cap_edge && !stop_wr;
    assign wrap = tick && !stop_wr && &count_reg && !start_pend_reg && !cap_iv
        && (state_reg == tcm_pkg::st_count || state_reg == tcm_pkg::st_measure);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            unit_power_enable_reg <= 1'b0;
        end else if (wr && reg_hit(addr, `TCM_OFS_POWER)) begin
            unit_power_enable_reg <= wdata[`TCM_POWER_BIT];
        end
    end

    // Software may only touch edge select while running; not enforced here
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            channel_mode_reg <= `TCM_MODE_RESET;
            rx_to_timer_route_bit_reg <= 1'b0;
            presc_reg <= `TCM_PRESC_RESET;
        end else if (!unit_power_enable_reg) begin
            channel_mode_reg <= `TCM_MODE_RESET;
            rx_to_timer_route_bit_reg <= 1'b0;
            presc_reg <= `TCM_PRESC_RESET;
        end else if (wr_on) begin
            if (reg_hit(addr, `TCM_OFS_MODE)) begin
                channel_mode_reg <= wdata[`TCM_MODE_W-1:0];
            end
            if (reg_hit(addr, `TCM_OFS_SWITCH)) begin
                rx_to_timer_route_bit_reg <= wdata[`TCM_ROUTE_BIT];
            end
            if (reg_hit(addr, `TCM_OFS_PRESC)) begin
                presc_reg <= wdata[2*`TCM_EXP_W-1:0];
            end
        end
    end

    // Channel control: enabled flag, mode state and pending triggers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            channel_enabled_flag_reg <= 1'b0;
            state_reg <= tcm_pkg::st_idle;
            start_pend_reg <= 1'b0;
            swcap_reg <= 1'b0;
        end else if (!unit_power_enable_reg) begin
            channel_enabled_flag_reg <= 1'b0;
            state_reg <= tcm_pkg::st_idle;
            start_pend_reg <= 1'b0;
            swcap_reg <= 1'b0;
        end else if (stop_wr) begin
            channel_enabled_flag_reg <= 1'b0;
            state_reg <= tcm_pkg::st_idle;
            start_pend_reg <= 1'b0;
            swcap_reg <= 1'b0;
        end else if (start_wr) begin
            if (is_interval) begin
                if (channel_enabled_flag_reg) begin
                    swcap_reg <= 1'b1;
                end else begin
                    channel_enabled_flag_reg <= 1'b1;
                    state_reg <= tcm_pkg::st_count;
                    start_pend_reg <= 1'b1;
                end
            end else if (!channel_enabled_flag_reg) begin
                // A start while enabled would corrupt a width, so it is dropped
                channel_enabled_flag_reg <= 1'b1;
                state_reg <= tcm_pkg::st_wait;
            end
        end else begin
            if (tick) begin
                start_pend_reg <= 1'b0;
                swcap_reg <= 1'b0;
            end
            case (state_reg)
                tcm_pkg::st_wait: begin
                    if (start_edge) begin
                        state_reg <= tcm_pkg::st_measure;
                    end
                end
                tcm_pkg::st_measure: begin
                    if (cap_edge) begin
                        state_reg <= tcm_pkg::st_wait;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Counter; a stop in the same cycle wins so the held value is exact
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else if (!unit_power_enable_reg) begin
            count_reg <= '0;
        end else if (!stop_wr) begin
            case (state_reg)
                tcm_pkg::st_count: begin
                    if (start_tick || cap_iv) begin
                        count_reg <= '0;
                    end else if (tick) begin
                        count_reg <= count_reg + CNT_W'(1);
                    end
                end
                tcm_pkg::st_wait: begin
                    if (start_edge) begin
                        count_reg <= '0;
                    end
                end
                tcm_pkg::st_measure: begin
                    if (cap_edge || tick) begin
                        count_reg <= count_reg + CNT_W'(1);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Pending overflow is sticky over any number of wraps; set beats clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ovf_pend_reg <= 1'b0;
        end else if (!unit_power_enable_reg) begin
            ovf_pend_reg <= 1'b0;
        end else if (wrap) begin
            ovf_pend_reg <= 1'b1;
        end else if (cap_iv || cap_w || start_tick || (state_reg == tcm_pkg::st_wait && start_edge)) begin
            ovf_pend_reg <= 1'b0;
        end
    end

    // Capture value plus one, with the flag weighted 10000h, gives the period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            capture_reg <= '0;
            overflow_flag_reg <= 1'b0;
        end else if (!unit_power_enable_reg) begin
            capture_reg <= '0;
            overflow_flag_reg <= 1'b0;
        end else if (cap_iv || cap_w) begin
            capture_reg <= count_reg;
            overflow_flag_reg <= ovf_pend_reg;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= unit_power_enable_reg
                && (cap_iv || cap_w || (start_tick && channel_mode_reg.start_interrupt_mode_bit));
        end
    end

    always_comb begin
        rdata_next = '0;
        if (rd && reg_hit(addr, `TCM_OFS_POWER)) begin
            rdata_next[`TCM_POWER_BIT] = unit_power_enable_reg;
        end else if (rd && unit_power_enable_reg) begin
            case (addr)
                `TCM_OFS_MODE: rdata_next = `TCM_DATA_W'(channel_mode_reg);
                `TCM_OFS_ENABLED: rdata_next[`TCM_ENABLED_BIT] = channel_enabled_flag_reg;
                `TCM_OFS_CAPTURE: rdata_next = `TCM_DATA_W'(capture_reg);
                `TCM_OFS_COUNT: rdata_next = `TCM_DATA_W'(count_reg);
                `TCM_OFS_STATUS: rdata_next[`TCM_OVF_BIT] = overflow_flag_reg;
                `TCM_OFS_SWITCH: rdata_next[`TCM_ROUTE_BIT] = rx_to_timer_route_bit_reg;
                `TCM_OFS_PRESC: rdata_next = `TCM_DATA_W'(presc_reg);
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign channel_interrupt = irq_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_start_from_zero: assert property (start_tick && !stop_wr |=> count_reg == '0)
        else $error("counter not zero after interval start");
    a_interval_capture: assert property (cap_iv && unit_power_enable_reg
        |=> capture_reg == $past(count_reg) && count_reg == '0 && channel_interrupt)
        else $error("interval capture did not store, clear and interrupt together");
    a_ovf_update: assert property ((cap_iv || cap_w) && unit_power_enable_reg
        |=> overflow_flag_reg == $past(ovf_pend_reg))
        else $error("overflow flag not updated at capture");
    a_ovf_sticky: assert property (wrap && unit_power_enable_reg
        ##1 (!cap_iv && !cap_w && !start_tick && !(state_reg == tcm_pkg::st_wait && start_edge)
        && unit_power_enable_reg) |=> ovf_pend_reg)
        else $error("pending overflow lost before capture");
    a_sw_capture: assert property (start_wr && is_interval && channel_enabled_flag_reg
        |=> swcap_reg || channel_interrupt)
        else $error("software capture request not taken");
    a_start_irq_gate: assert property (start_tick && !channel_mode_reg.start_interrupt_mode_bit
        |=> !channel_interrupt)
        else $error("start interrupt raised with mode bit clear");
    a_stop_holds: assert property (stop_wr
        |=> !channel_enabled_flag_reg && count_reg == $past(count_reg)
        && overflow_flag_reg == $past(overflow_flag_reg))
        else $error("stop did not halt and hold the channel");
    a_trigger_readzero: assert property (rd && (reg_hit(addr, `TCM_OFS_START)
        || reg_hit(addr, `TCM_OFS_STOP)) |=> rdata == '0)
        else $error("trigger register read back non-zero");
    a_width_stop: assert property (cap_w && unit_power_enable_reg
        |=> (count_reg == $past(count_reg) + CNT_W'(1) && state_reg == tcm_pkg::st_wait)
        and (!start_edge && unit_power_enable_reg |=> $stable(count_reg)))
        else $error("width counter not parked at capture plus one");
    a_power_off: assert property (!unit_power_enable_reg
        |=> count_reg == '0 && !channel_enabled_flag_reg && !channel_interrupt)
        else $error("channel not held initialised while powered off");

    c_interval_capture: cover property (cap_iv && iv_edge);
    c_sw_capture: cover property (cap_iv && swcap_reg);
    c_width_capture: cover property (cap_w);
    c_ovf_capture: cover property ((cap_iv || cap_w) && ovf_pend_reg);

endmodule : tcm_channel

// ### verification/tcm_pulse_src.sv
/*
 * Far-side pulse source: drives one pulse of a set polarity and length
 * on the timer pin or, when routed, on the serial receive line.
 * Assumes go is a one-cycle request and width is at least 1.
 */
`timescale 1ns/100ps

module tcm_pulse_src (
    input wire logic clock,
    input wire logic go,
    input wire logic pol,
    input wire logic route,
    input wire logic [16:0] width,
    output logic timer_input,
    output logic serial_receive_input
);
    logic [16:0] left_reg = 17'h0;
    logic act;

    always_ff @(posedge clock) begin
        if (go)
            left_reg <= width;
        else if (left_reg != 17'h0)
            left_reg <= left_reg - 17'h1;
    end

    assign act = (left_reg != 17'h0) ? pol : ~pol;
    assign timer_input = route ? ~pol : act;
    // Receive line sits high while not routed, like an idle serial link; when routed it carries the pulse
    assign serial_receive_input = route ? act : 1'h1;
endmodule : tcm_pulse_src

// ### verification/tcm_channel_test.sv
/*
 * Self-checking bench for the timer capture channel.
 * Assumes the pulse source model and a 100 MHz clock; prescaler set to 0.
 */
`timescale 1ns/100ps
`include "tcm_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module tcm_channel_test;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0, rd = 1'h0, go = 1'h0, pol = 1'h1, route = 1'h0;
    logic [16:0] width = 17'h0;
    logic [31:0] rdata, got, held;
    logic timer_input, serial_receive_input, channel_interrupt;
    int n_mismatch = 0, comparisons = 0, n;

    initial forever #5 clock = ~clock;

    tcm_channel u_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_input(timer_input), .serial_receive_input(serial_receive_input),
        .channel_interrupt(channel_interrupt));
    tcm_pulse_src u_src (.clock(clock), .go(go), .pol(pol), .route(route), .width(width),
        .timer_input(timer_input), .serial_receive_input(serial_receive_input));

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        #1;
        got = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd_reg(a);
        `CHK(nm, e, got)
    endtask : rd_chk

    task automatic wait_irq;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (channel_interrupt !== 1'h1 && n < 300);
        if (channel_interrupt !== 1'h1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_irq

    task automatic fire(input logic [16:0] w);
        @(posedge clock);
        go <= 1'h1;
        width <= w;
        @(posedge clock);
        go <= 1'h0;
    endtask : fire

    // Two rising edges p cycles apart; the interrupt latency is subtracted
    task automatic interval(input int p);
        fire(17'h5);
        wait_irq();
        repeat (p - n - 2) @(posedge clock);
        fire(17'h5);
        wait_irq();
    endtask : interval

    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'h1;
        rd_chk(`TCM_OFS_POWER, 32'h0, "power");
        wr_reg(`TCM_OFS_MODE, 32'h42);
        rd_chk(`TCM_OFS_MODE, 32'h0, "mode unpowered");
        wr_reg(`TCM_OFS_POWER, 32'h1);
        rd_chk(`TCM_OFS_MODE, 32'h0, "mode write ignored");
        wr_reg(`TCM_OFS_PRESC, 32'h0);
        wr_reg(`TCM_OFS_MODE, 32'h42);
        wr_reg(`TCM_OFS_START, 32'h1);
        rd_chk(`TCM_OFS_ENABLED, 32'h1, "enabled");
        rd_chk(`TCM_OFS_START, 32'h0, "start");
        rd_chk(8'h40, 32'h0, "unmapped");
        interval(40);
        rd_chk(`TCM_OFS_CAPTURE, 32'h27, "capture");
        rd_chk(`TCM_OFS_STATUS, 32'h0, "overflow");
        wr_reg(`TCM_OFS_START, 32'h1);
        wait_irq();
        rd_chk(`TCM_OFS_CAPTURE, 32'h6, "sw capture");
        interval(66000);
        rd_chk(`TCM_OFS_CAPTURE, 32'h1cf, "capture wrapped");
        rd_chk(`TCM_OFS_STATUS, 32'h1, "overflow set");
        wr_reg(`TCM_OFS_STOP, 32'h1);
        rd_chk(`TCM_OFS_ENABLED, 32'h0, "stopped");
        rd_chk(`TCM_OFS_STOP, 32'h0, "stop");
        rd_chk(`TCM_OFS_STATUS, 32'h1, "overflow held");
        rd_reg(`TCM_OFS_COUNT);
        held = got;
        repeat (20) @(posedge clock);
        rd_chk(`TCM_OFS_COUNT, held, "count held");
        wr_reg(`TCM_OFS_MODE, 32'hd2);
        wr_reg(`TCM_OFS_START, 32'h1);
        fire(17'h19);
        wait_irq();
        rd_chk(`TCM_OFS_CAPTURE, 32'h18, "high width");
        rd_chk(`TCM_OFS_COUNT, 32'h19, "count stop");
        rd_chk(`TCM_OFS_STATUS, 32'h0, "overflow cleared");
        fire(17'ha);
        wait_irq();
        rd_chk(`TCM_OFS_CAPTURE, 32'h9, "second width");
        wr_reg(`TCM_OFS_STOP, 32'h1);
        pol <= 1'h0;
        wr_reg(`TCM_OFS_MODE, 32'h92);
        wr_reg(`TCM_OFS_START, 32'h1);
        fire(17'hf);
        wait_irq();
        rd_chk(`TCM_OFS_CAPTURE, 32'he, "low width");
        wr_reg(`TCM_OFS_STOP, 32'h1);
        pol <= 1'h1;
        route <= 1'h1;
        wr_reg(`TCM_OFS_SWITCH, 32'h2);
        wr_reg(`TCM_OFS_MODE, 32'h43);
        wr_reg(`TCM_OFS_START, 32'h1);
        wait_irq();
        interval(30);
        rd_chk(`TCM_OFS_CAPTURE, 32'h1d, "routed capture");
        wr_reg(`TCM_OFS_POWER, 32'h0);
        wr_reg(`TCM_OFS_POWER, 32'h1);
        rd_chk(`TCM_OFS_CAPTURE, 32'h0, "capture after power off");
        print_verdict();
    end
endmodule : tcm_channel_test
